// file: src/scr_map.vh
// constants for the serial flash continuous read front end
`ifndef SCR_MAP_VH
`define SCR_MAP_VH

// memory organisation
`define SCR_PAGE_COUNT 4096
`define SCR_PAGE_BYTES 264
`define SCR_LAST_BYTE 9'h107
`define SCR_BLOCK_PAGES 8
`define SCR_BLOCK_BYTES 12'h840
`define SCR_ARRAY_BYTES 21'h108000
`define SCR_ARRAY_LAST 21'h107FFF
`define SCR_BUF_LAST 9'h107

// operation codes
`define SCR_OP_ARRAY_READ_LEGACY 8'h68
`define SCR_OP_ARRAY_READ_SPI 8'hE8
`define SCR_OP_BUF1_WRITE 8'h84
`define SCR_OP_BUF2_WRITE 8'h87
`define SCR_OP_BUF1_PROG_ERASE 8'h83
`define SCR_OP_BUF2_PROG_ERASE 8'h86
`define SCR_OP_BUF1_PROG 8'h88
`define SCR_OP_BUF2_PROG 8'h89
// erase codes: arbitrary values
`define SCR_OP_PAGE_ERASE 8'hF1
`define SCR_OP_BLOCK_ERASE 8'hF2

// frame bit counts on the serial input
`define SCR_OPCODE_BITS 7'h08
`define SCR_HEADER_BITS 7'h20
`define SCR_DUMMY_END 7'h40
`define SCR_CNT_TOP 7'h7F
`define SCR_CNT_REWIND 7'h78

// address field layout in the 32-bit header (opcode in bits 31:24)
`define SCR_PAGE_MSB 20
`define SCR_PAGE_LSB 9
`define SCR_BYTE_MSB 8
`define SCR_BYTE_LSB 0

// reset values
`define SCR_ERASED_BYTE 8'hFF
`define SCR_SO_RESET 1'b0

`endif

// file: src/scr_array.v
// main flash array storage with one read port and one program port
`include "scr_map.vh"
`default_nettype none

module scr_array (
    input wire ref_clk,
    input wire [20:0] rd_addr,
    output reg [7:0] rd_data,
    input wire wr_en,
    input wire wr_and,
    input wire [20:0] wr_addr,
    input wire [7:0] wr_data
);

    // whole array, one byte per word
    reg [7:0] mem [0:`SCR_ARRAY_BYTES-1];
    integer i;

    // parts leave the line erased
    initial begin
        for (i = 0; i < `SCR_ARRAY_BYTES; i = i + 1) begin
            mem[i] = `SCR_ERASED_BYTE;
        end
    end

    // registered read; out-of-range indices read erased
    always @(posedge ref_clk) begin
        if (rd_addr > `SCR_ARRAY_LAST) begin
            rd_data <= `SCR_ERASED_BYTE;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end

    // program port: and-mode only clears bits, as flash cells do
    always @(posedge ref_clk) begin
        if (wr_en && (wr_addr <= `SCR_ARRAY_LAST)) begin
            if (wr_and) begin
                mem[wr_addr] <= mem[wr_addr] & wr_data;
            end else begin
                mem[wr_addr] <= wr_data;
            end
        end
    end

endmodule

`default_nettype wire

// file: src/scr_top.v
// serial flash command front end with continuous array read
`include "scr_map.vh"
`default_nettype none
// How it works
// - frame opens at chip select fall, opcode first
// - serial input sampled one bit per clock
// - everything shifts most significant bit first
// - nine-bit byte address selects buffer location
// - twelve-bit page plus nine-bit byte address
// - two read opcodes, 24 address, 32 dummy
// - three reserved, twelve page, nine byte bits
// - data bit out on each later clock
// - internal address counter advances while streaming
// - page end rolls to next page, no gap
// - array end wraps to first page, no gap
// - chip select rise ends read, output released
// - continuous read never touches the buffers
// - 4096 pages of 264 bytes, two buffers
// - whole-page program, page or block erase
// - read opcode picks output clock edge
// - programming self-timed, 83/86 need no separate erase

module scr_top (
    input wire ref_clk,
    input wire resetn,
    input wire cs_n,
    input wire sck,
    input wire si,
    output reg so_out,
    output reg so_oe,
    output reg ready
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // page and byte to linear array index
    function [20:0] lin_addr;
        input [11:0] page;
        input [8:0] byte_ofs;
        begin
            lin_addr = (({9'h000, page} << 8) + ({9'h000, page} << 3)) + {12'h000, byte_ofs};
        end
    endfunction

    // engine states
    localparam [1:0] ENG_IDLE = 2'b00;
    localparam [1:0] ENG_RUN = 2'b01;
    localparam [1:0] ENG_DONE = 2'b10;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge detection

    reg cs_s1_reg, cs_s2_reg, cs_d_reg; // chip select chain
    reg sck_s1_reg, sck_s2_reg, sck_d_reg; // serial clock chain
    reg si_s1_reg, si_s2_reg; // serial data chain

    // pins come from the host's domain; only stage two and its delayed copy are looked at
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            cs_d_reg <= 1'b1;
            sck_s1_reg <= 1'b0;
            sck_s2_reg <= 1'b0;
            sck_d_reg <= 1'b0;
            si_s1_reg <= 1'b0;
            si_s2_reg <= 1'b0;
        end else begin
            cs_s1_reg <= cs_n;
            cs_s2_reg <= cs_s1_reg;
            cs_d_reg <= cs_s2_reg;
            sck_s1_reg <= sck;
            sck_s2_reg <= sck_s1_reg;
            sck_d_reg <= sck_s2_reg;
            si_s1_reg <= si;
            si_s2_reg <= si_s1_reg;
        end
    end

    wire sel = ~cs_s2_reg; // frame open
    wire cs_fall = cs_d_reg & ~cs_s2_reg;
    wire cs_rise = ~cs_d_reg & cs_s2_reg;
    wire sck_rise = sel & ~sck_d_reg & sck_s2_reg;
    wire sck_fall = sel & sck_d_reg & ~sck_s2_reg;

    ////////////////////////////////////////////////////////////////////////////
    // command shifter

    reg [31:0] in_sr_reg; // last 32 bits taken in
    reg [6:0] cnt_reg; // bits taken this frame
    reg [7:0] op_reg; // latched opcode
    reg [11:0] page_reg; // latched page address
    reg [8:0] byte_reg; // latched byte address

    wire [31:0] in_sr_next = {in_sr_reg[30:0], si_s2_reg};
    // counter rewinds inside the top octet so byte alignment survives long frames
    wire [6:0] cnt_next = (cnt_reg == `SCR_CNT_TOP) ? `SCR_CNT_REWIND : cnt_reg + 7'h01;

    // opcode class decode
    wire op_read = (op_reg == `SCR_OP_ARRAY_READ_LEGACY) ||
                   (op_reg == `SCR_OP_ARRAY_READ_SPI);
    wire op_spi = (op_reg == `SCR_OP_ARRAY_READ_SPI);
    wire op_bufwr = (op_reg == `SCR_OP_BUF1_WRITE) || (op_reg == `SCR_OP_BUF2_WRITE);
    wire op_prog_e = (op_reg == `SCR_OP_BUF1_PROG_ERASE) ||
                     (op_reg == `SCR_OP_BUF2_PROG_ERASE);
    wire op_prog = (op_reg == `SCR_OP_BUF1_PROG) || (op_reg == `SCR_OP_BUF2_PROG);
    wire op_buf2 = (op_reg == `SCR_OP_BUF2_WRITE) || (op_reg == `SCR_OP_BUF2_PROG_ERASE) ||
                   (op_reg == `SCR_OP_BUF2_PROG);
    wire op_perase = (op_reg == `SCR_OP_PAGE_ERASE);
    wire op_berase = (op_reg == `SCR_OP_BLOCK_ERASE);
    wire op_engine = op_prog_e | op_prog | op_perase | op_berase;

    // shift on rising serial clock while selected; new frame restarts
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            in_sr_reg <= 32'h00000000;
            cnt_reg <= 7'h00;
            op_reg <= 8'h00;
            page_reg <= 12'h000;
            byte_reg <= 9'h000;
        end else if (cs_fall) begin
            cnt_reg <= 7'h00;
            op_reg <= 8'h00;
        end else if (sck_rise) begin
            in_sr_reg <= in_sr_next;
            cnt_reg <= cnt_next;
            if (cnt_next == `SCR_OPCODE_BITS) begin
                op_reg <= in_sr_next[7:0];
            end
            if (cnt_next == `SCR_HEADER_BITS) begin
                // top three address bits are reserved and dropped
                page_reg <= in_sr_next[`SCR_PAGE_MSB:`SCR_PAGE_LSB];
                byte_reg <= in_sr_next[`SCR_BYTE_MSB:`SCR_BYTE_LSB];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // data buffers

    reg [7:0] buf_one [0:`SCR_PAGE_BYTES-1];
    reg [7:0] buf_two [0:`SCR_PAGE_BYTES-1];
    reg [8:0] bptr_reg; // buffer write pointer

    // a data byte completes on every eighth bit after the header
    wire bw_hit = sck_rise && op_bufwr && (cnt_next > `SCR_HEADER_BITS) &&
                  (cnt_next[2:0] == 3'h0);

    // buffer pointer: loaded from the header, wraps past the last byte
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            bptr_reg <= 9'h000;
        end else if (sck_rise && (cnt_next == `SCR_HEADER_BITS)) begin
            bptr_reg <= in_sr_next[8:0];
        end else if (bw_hit) begin
            bptr_reg <= (bptr_reg >= `SCR_BUF_LAST) ? 9'h000 : bptr_reg + 9'h001;
        end
    end

    // storage write; only buffer-write frames reach here
    always @(posedge ref_clk) begin
        if (bw_hit && (bptr_reg <= `SCR_BUF_LAST)) begin
            if (op_buf2) begin
                buf_two[bptr_reg] <= in_sr_next[7:0];
            end else begin
                buf_one[bptr_reg] <= in_sr_next[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // continuous array read

    reg armed_reg; // dummy bits done, output phase on
    reg [11:0] rd_page_reg; // streaming page counter
    reg [8:0] rd_byte_reg; // streaming byte counter
    reg [7:0] out_sr_reg; // bits left of the current byte
    reg [2:0] out_idx_reg; // bit position, 0 means fetch
    wire [7:0] mem_q; // array byte at the read counters

    // mode E8 moves on falling edges, mode 68 one rising edge later
    wire out_edge = armed_reg & (op_spi ? sck_fall : sck_rise);

    // read side; the array is read directly, buffers untouched
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            armed_reg <= 1'b0;
            rd_page_reg <= 12'h000;
            rd_byte_reg <= 9'h000;
            out_sr_reg <= 8'h00;
            out_idx_reg <= 3'h0;
            so_out <= `SCR_SO_RESET;
            so_oe <= 1'b0;
        end else if (!sel) begin
            armed_reg <= 1'b0;
            so_oe <= 1'b0;
            so_out <= `SCR_SO_RESET;
            out_idx_reg <= 3'h0;
        end else begin
            if (sck_rise && (cnt_next == `SCR_HEADER_BITS)) begin
                rd_page_reg <= in_sr_next[`SCR_PAGE_MSB:`SCR_PAGE_LSB];
                rd_byte_reg <= in_sr_next[`SCR_BYTE_MSB:`SCR_BYTE_LSB];
            end
            // a busy device does not stream; output stays released
            if (sck_rise && (cnt_next == `SCR_DUMMY_END) && op_read && ready) begin
                armed_reg <= 1'b1;
            end
            if (out_edge) begin
                so_oe <= 1'b1;
                if (out_idx_reg == 3'h0) begin
                    so_out <= mem_q[7];
                    out_sr_reg <= {mem_q[6:0], 1'b0};
                    // move the counter on at once; next byte is ready long before use
                    if (rd_byte_reg >= `SCR_LAST_BYTE) begin
                        rd_byte_reg <= 9'h000;
                        rd_page_reg <= rd_page_reg + 12'h001;
                    end else begin
                        rd_byte_reg <= rd_byte_reg + 9'h001;
                    end
                end else begin
                    so_out <= out_sr_reg[7];
                    out_sr_reg <= {out_sr_reg[6:0], 1'b0};
                end
                out_idx_reg <= out_idx_reg + 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // self-timed program and erase engine

    reg [1:0] eng_state_reg; // engine state
    reg [20:0] eng_base_reg; // first linear byte
    reg [11:0] eng_len_reg; // bytes to walk
    reg [11:0] eng_cnt_reg; // bytes walked
    reg eng_erase_reg; // write erased value
    reg eng_and_reg; // clear bits only
    reg eng_buf2_reg; // source buffer
    reg mw_en_reg; // array write strobe
    reg mw_and_reg; // array write mode
    reg [20:0] mw_addr_reg; // array write index
    reg [7:0] mw_data_reg; // array write byte

    // a frame counts only when its full header arrived
    wire launch = cs_rise && op_engine && (cnt_reg >= `SCR_HEADER_BITS) &&
                  (eng_state_reg == ENG_IDLE);

    // engine: one byte per clock over a page or a block
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            eng_state_reg <= ENG_IDLE;
            eng_base_reg <= 21'h000000;
            eng_len_reg <= 12'h000;
            eng_cnt_reg <= 12'h000;
            eng_erase_reg <= 1'b0;
            eng_and_reg <= 1'b0;
            eng_buf2_reg <= 1'b0;
            mw_en_reg <= 1'b0;
            mw_and_reg <= 1'b0;
            mw_addr_reg <= 21'h000000;
            mw_data_reg <= 8'h00;
            ready <= 1'b1;
        end else begin
            mw_en_reg <= 1'b0;
            case (eng_state_reg)
                ENG_IDLE: begin
                    if (launch) begin
                        ready <= 1'b0;
                        eng_state_reg <= ENG_RUN;
                        eng_cnt_reg <= 12'h000;
                        eng_erase_reg <= op_perase | op_berase;
                        eng_and_reg <= op_prog; // prior erase assumed
                        eng_buf2_reg <= op_buf2;
                        if (op_berase) begin
                            // block is eight aligned pages
                            eng_base_reg <= lin_addr({page_reg[11:3], 3'h0}, 9'h000);
                            eng_len_reg <= `SCR_BLOCK_BYTES;
                        end else begin
                            eng_base_reg <= lin_addr(page_reg, 9'h000);
                            eng_len_reg <= {3'h0, `SCR_LAST_BYTE} + 12'h001;
                        end
                    end
                end
                ENG_RUN: begin
                    // one pass: 83/86 plain-write the buffer, 88/89 and-write it, erase opcodes write the erased value
                    mw_en_reg <= 1'b1;
                    mw_and_reg <= eng_and_reg;
                    mw_addr_reg <= eng_base_reg + {9'h000, eng_cnt_reg};
                    if (eng_erase_reg) begin
                        mw_data_reg <= `SCR_ERASED_BYTE;
                    end else if (eng_buf2_reg) begin
                        mw_data_reg <= buf_two[eng_cnt_reg[8:0]];
                    end else begin
                        mw_data_reg <= buf_one[eng_cnt_reg[8:0]];
                    end
                    if (eng_cnt_reg == eng_len_reg - 12'h001) begin
                        eng_state_reg <= ENG_DONE;
                    end
                    eng_cnt_reg <= eng_cnt_reg + 12'h001;
                end
                ENG_DONE: begin
                    // last write lands this cycle
                    ready <= 1'b1;
                    eng_state_reg <= ENG_IDLE;
                end
                default: begin
                    eng_state_reg <= ENG_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // main array

    // read port follows the streaming counters
    scr_array u_array (
        .ref_clk(ref_clk),
        .rd_addr(lin_addr(rd_page_reg, rd_byte_reg)),
        .rd_data(mem_q),
        .wr_en(mw_en_reg),
        .wr_and(mw_and_reg),
        .wr_addr(mw_addr_reg),
        .wr_data(mw_data_reg)
    );

endmodule

`default_nettype wire

// file: bench/scr_top_chk.sv
// pin-level assertion checker for the serial flash front end
`default_nettype none

module scr_top_chk (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic so_out,
    input wire logic so_oe,
    input wire logic ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic sck_q; // last sampled serial clock
    logic [7:0] rise_cnt; // clock rises in this frame
    logic [11:0] busy_cnt; // cycles spent busy so far

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    ////////////////////////////////////////////////////////////////////////
    // rise counter saturates so long read-outs cannot wrap it
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sck_q <= 1'b0;
            rise_cnt <= 8'h00;
            busy_cnt <= 12'h000;
        end else begin
            sck_q <= sck;
            if (cs_n) begin // frame closed
                rise_cnt <= 8'h00;
            end else if (sck && !sck_q && rise_cnt != 8'hFF) begin
                rise_cnt <= rise_cnt + 8'h01;
            end
            busy_cnt <= ready ? 12'h000 : busy_cnt + 12'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    cs_release_a: assert property (cs_n [*6] |-> !so_oe)
        else $error("output still enabled after deselect");
    oe_fall_a: assert property ($fell(so_oe) |-> $past(cs_n, 2))
        else $error("output released while still selected");
    idle_low_a: assert property (!so_oe |-> !so_out)
        else $error("data high while output released");
    oe_edge_a: assert property ($rose(so_oe) |-> $past(sck, 2) != $past(sck, 5))
        else $error("output enabled away from a clock edge");
    bit_edge_a: assert property (so_oe && $past(so_oe) && so_out != $past(so_out)
        |-> $past(sck, 2) != $past(sck, 5))
        else $error("data bit changed away from a clock edge");
    dummy_count_a: assert property ($rose(so_oe) |-> rise_cnt == 8'h40 || rise_cnt == 8'h41)
        else $error("data started after wrong number of clocks");
    ready_arm_a: assert property ($rose(so_oe) |-> ready)
        else $error("read armed while busy");
    busy_time_a: assert property ($rose(ready) |-> busy_cnt == 12'h109 || busy_cnt == 12'h841)
        else $error("busy time wrong");
endmodule

bind scr_top scr_top_chk chk (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .cs_n(cs_n),
    .sck(sck),
    .si(si),
    .so_out(so_out),
    .so_oe(so_oe),
    .ready(ready)
);

`default_nettype wire

// file: bench/scr_host.sv
// host serial master model: chip select, serial clock and data in
`default_nettype none

module scr_host (
    input wire logic ref_clk,
    output logic cs_n,
    output logic sck,
    output logic si,
    input wire logic so_out,
    input wire logic so_oe
);
    timeunit 1ns;
    timeprecision 1ns;

    ////////////////////////////////////////////////////////////////////////
    // idle: deselected, clock parked low, stands still between frames
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end

    // frame opens with chip select fall
    task automatic open();
        @(negedge ref_clk);
        cs_n = 1'b0;
        repeat (4) @(negedge ref_clk);
    endtask

    // select held to here; data in toggled since its hold has run out
    task automatic close();
        repeat (4) @(negedge ref_clk);
        cs_n = 1'b1;
        si = ~si;
        repeat (16) @(negedge ref_clk);
    endtask

    // one byte each way; late takes the bit seen before the falling edge
    task automatic xfer(input logic [7:0] v, input logic late, output logic [7:0] q);
        logic r;
        logic f;
        for (int i = 7; i >= 0; i--) begin
            si = v[i];
            repeat (4) @(negedge ref_clk);
            r = so_oe ? so_out : 1'bz; // released line reads as z
            sck = 1'b1;
            repeat (4) @(negedge ref_clk);
            f = so_oe ? so_out : 1'bz;
            sck = 1'b0;
            q[i] = late ? f : r;
        end
    endtask
endmodule

`default_nettype wire

// file: bench/scr_top_tb.sv
// self-checking bench for the serial flash continuous read front end
`include "scr_map.vh"
`default_nettype none

module scr_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk; // 50 MHz system clock
    logic resetn; // async reset, active low
    wire cs_n; // host pins
    wire sck;
    wire si;
    wire so_out; // device pins
    wire so_oe;
    wire ready;
    int fail_count; // mismatches
    int comparisons; // checks made
    logic [7:0] tx[$]; // payload for the next frame
    logic [7:0] got[$]; // bytes read back

    scr_top dut (.ref_clk(ref_clk), .resetn(resetn), .cs_n(cs_n), .sck(sck), .si(si),
        .so_out(so_out), .so_oe(so_oe), .ready(ready));
    scr_host host (.ref_clk(ref_clk), .cs_n(cs_n), .sck(sck), .si(si),
        .so_out(so_out), .so_oe(so_oe));

    ////////////////////////////////////////////////////////////////////////
    // clock
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk1(input logic g, input logic e);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // framed command: header, dummy bytes for reads, payload, read-out
    task automatic frame(input logic [7:0] op, input logic [23:0] a, input int nrd);
        logic late;
        logic [7:0] q;
        int nd;
        late = (op == `SCR_OP_ARRAY_READ_LEGACY);
        nd = (late || op == `SCR_OP_ARRAY_READ_SPI) ? 4 : 0;
        got = {};
        host.open();
        host.xfer(op, late, q);
        chk8(q, 8'hZZ);
        for (int i = 2; i >= 0; i--) begin
            host.xfer(a[i*8 +: 8], late, q);
            chk8(q, 8'hZZ);
        end
        for (int i = 0; i < nd + tx.size(); i++) begin
            host.xfer(i < nd ? 8'h00 : tx[i - nd], late, q);
            chk8(q, 8'hZZ);
        end
        for (int i = 0; i < nrd; i++) begin
            host.xfer(8'h00, late, q);
            got.push_back(q);
        end
        host.close();
        chk1(so_oe, 1'b0);
        tx = {};
    endtask

    // bounded wait for the self-timed program to finish
    task automatic wait_ready();
        int n;
        n = 0;
        chk1(ready, 1'b0);
        while (ready !== 1'b1 && n < 3000) begin
            @(negedge ref_clk);
            n++;
        end
        chk1(ready, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk1(so_oe, 1'b0);
        chk1(so_out, 1'b0);
        chk1(ready, 1'b1);
        $display("test reset done");
    endtask

    // buffer 1 written across its end, so the last byte wraps to 0
    task automatic t_load();
        tx = {8'hA1, 8'hA2, 8'h5A};
        frame(`SCR_OP_BUF1_WRITE, {15'h0000, 9'h106}, 0);
        frame(`SCR_OP_BUF1_PROG_ERASE, {3'h0, 12'hFFF, 9'h000}, 0);
        wait_ready();
        tx = {8'hC3, 8'h3C};
        frame(`SCR_OP_BUF2_WRITE, 24'h000000, 0);
        frame(`SCR_OP_BUF2_PROG_ERASE, 24'h000000, 0);
        wait_ready();
        $display("test load done");
    endtask

    // reserved bits set; read runs off the last page into page 0
    task automatic t_wrap();
        frame(`SCR_OP_ARRAY_READ_SPI, {3'h7, 12'hFFF, 9'h106}, 4);
        chk8(got[0], 8'hA1);
        chk8(got[1], 8'hA2);
        chk8(got[2], 8'hC3);
        chk8(got[3], 8'h3C);
        $display("test wrap done");
    endtask

    // rising-edge read mode across a page boundary
    task automatic t_cross();
        frame(`SCR_OP_ARRAY_READ_LEGACY, {3'h0, 12'hFFE, 9'h107}, 2);
        chk8(got[0], `SCR_ERASED_BYTE);
        chk8(got[1], 8'h5A);
        $display("test cross done");
    endtask

    // program without erase only clears bits
    task automatic t_and();
        frame(`SCR_OP_BUF1_PROG, 24'h000000, 0);
        wait_ready();
        frame(`SCR_OP_ARRAY_READ_SPI, 24'h000000, 1);
        chk8(got[0], 8'h42);
        $display("test and done");
    endtask

    // buffer 2 must survive the reads above
    task automatic t_keep();
        frame(`SCR_OP_BUF2_PROG_ERASE, {3'h0, 12'h001, 9'h000}, 0);
        wait_ready();
        frame(`SCR_OP_ARRAY_READ_LEGACY, {3'h0, 12'h001, 9'h000}, 2);
        chk8(got[0], 8'hC3);
        chk8(got[1], 8'h3C);
        $display("test keep done");
    endtask

    // block and page erase, a read refused while busy, program without erase from buffer 2
    task automatic t_erase();
        frame(`SCR_OP_BLOCK_ERASE, {3'h0, 12'h003, 9'h000}, 0);
        frame(`SCR_OP_ARRAY_READ_SPI, 24'h000000, 1);
        chk8(got[0], 8'hZZ);
        wait_ready();
        frame(`SCR_OP_PAGE_ERASE, {3'h0, 12'hFFF, 9'h000}, 0);
        wait_ready();
        frame(`SCR_OP_BUF2_PROG, {3'h0, 12'h002, 9'h000}, 0);
        wait_ready();
        frame(`SCR_OP_ARRAY_READ_LEGACY, {3'h0, 12'h001, 9'h107}, 3);
        chk8(got[0], `SCR_ERASED_BYTE);
        chk8(got[1], 8'hC3);
        chk8(got[2], 8'h3C);
        frame(`SCR_OP_ARRAY_READ_SPI, {3'h0, 12'hFFF, 9'h106}, 1);
        chk8(got[0], `SCR_ERASED_BYTE);
        $display("test erase done");
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        fail_count = 0;
        comparisons = 0;
        resetn = 1'b0;
        repeat (5) @(negedge ref_clk);
        resetn = 1'b1;
        repeat (4) @(negedge ref_clk);
        t_reset();
        t_load();
        t_wrap();
        t_cross();
        t_and();
        t_keep();
        t_erase();
        complete_run();
    end

    // watchdog: several times the expected run length
    initial begin
        repeat (40000) @(posedge ref_clk);
        fail_count++;
        $display("watchdog expired");
        complete_run();
    end
endmodule

`default_nettype wire
